// File: bus_master_model.sv
`default_nettype none
////////////////////////////////////////////////////////////////
module bus_master_model (
    // clock
    input  wire logic        mclk,
    // strobes and data towards the block
    output logic             reg_wr,
    output logic             reg_rd,
    output logic             reg_bcast,
    output logic      [5:0]  reg_addr,
    output logic      [15:0] reg_wdata,
    // read answer
    input  wire logic [15:0] reg_rdata,
    input  wire logic        reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus at time zero
    initial begin
        {reg_wr, reg_rd, reg_bcast} = 3'h0;
        {reg_addr, reg_wdata} = 22'h0;
    end
    // one-cycle write; released address and data are inverted so stale values never match, strobes drop to 0
    task automatic wr(input logic [5:0] a, input logic [15:0] d, input logic b);
        @(negedge mclk);
        {reg_addr, reg_wdata, reg_bcast, reg_wr} = {a, d, b, 1'b1};
        @(negedge mclk);
        {reg_addr, reg_wdata, reg_bcast, reg_wr} = {~a, ~d, 2'h0};
    endtask
    // one-cycle read; the answer is taken in the cycle after the strobe
    task automatic rd(input logic [5:0] a, output logic [15:0] d, output logic v);
        @(negedge mclk);
        {reg_addr, reg_rd} = {a, 1'b1};
        @(negedge mclk);
        {reg_addr, reg_rd} = {~a, 1'b0};
        {d, v} = {reg_rdata, reg_rvalid};
    endtask
endmodule
`default_nettype wire

// File: tb_temp_monitor_control_status.sv
`default_nettype none
////////////////////////////////////////////////////////////////
module tb_temp_monitor_control_status;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [5:0] A_ST = temp_monitor_pkg::OFS_DEVICE_STATUS;
    localparam logic [5:0] A_CT = temp_monitor_pkg::OFS_DEVICE_CONTROL;
    localparam logic [5:0] A_RO = temp_monitor_pkg::OFS_TEMP_READOUT;
    localparam logic [5:0] A_TC = temp_monitor_pkg::OFS_TEMP_CONTROL;
    logic mclk, rst_n, ce, reg_wr, reg_rd, reg_bcast, reg_rvalid, nack_event, remote_fault;
    logic attention_req, shutdown_active, low_power_active, function_two_enable, device_reset_busy;
    logic [5:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d, loc_w, rem_w, exp_w;
    logic [9:0]  local_temp, remote_temp;
    logic [3:0]  function_type_code;
    logic        v;
    int failures = 0, n_tests = 0, cyc = 0, n_att = 0, gap = 0, last = 0;
    // design and bus master
    temp_monitor_control_status #(.SLOT_CYCLES(8)) uut (.mclk(mclk), .rst_n(rst_n), .ce(ce),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_bcast(reg_bcast), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .nack_event(nack_event), .local_temp(local_temp), .remote_temp(remote_temp),
        .remote_fault(remote_fault), .attention_req(attention_req), .shutdown_active(shutdown_active),
        .low_power_active(low_power_active), .function_two_enable(function_two_enable),
        .device_reset_busy(device_reset_busy), .function_type_code(function_type_code));
    bus_master_model m (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_bcast(reg_bcast),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    ////////////////////////////////////////////////////////////////
    // clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // attention pulse counter and spacing, sampled away from the launching edge
    always @(negedge mclk) begin
        cyc <= cyc + 1;
        if (attention_req === 1'b1) begin
            n_att <= n_att + 1;
            gap   <= cyc - last;
            last  <= cyc;
        end
    end
    // compare and count
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // read that must answer with rvalid and the given word
    task automatic rd_chk(input logic [5:0] a, input logic [15:0] exp);
        m.rd(a, d, v);
        check(v === 1'b1 ? d : ~exp, exp);
    endtask
    // poll status until an event is pending, bounded
    task automatic wait_ev;
        for (int i = 0; i < 20; i++) begin
            m.rd(A_ST, d, v);
            if (d[0] === 1'b1) break;
        end
        check({15'h0, d[0]}, 16'h0001);
    endtask
    task automatic t_regs;
        rd_chk(A_CT, 16'h0000);
        rd_chk(temp_monitor_pkg::OFS_TEMP_CAPS, 16'h0349);
        rd_chk(A_ST, 16'h0000);
        check({12'h0, function_type_code}, 16'h0001);
        m.wr(A_CT, 16'hfffe, 1'b0);
        rd_chk(A_CT, 16'h0036);
        m.wr(A_CT, 16'h0000, 1'b1);
        rd_chk(A_CT, 16'h0034);
        m.wr(A_CT, 16'hfffe, 1'b1);
        rd_chk(A_CT, 16'h0036);
        check({15'h0, shutdown_active}, 16'h0001);
        m.wr(A_CT, 16'h0000, 1'b0);
        $display("test regs done");
    endtask
    task automatic t_berr;
        @(negedge mclk) nack_event = 1'b1;
        @(negedge mclk) nack_event = 1'b0;
        rd_chk(A_ST, 16'h0080);
        rd_chk(A_ST, 16'h0000);
        $display("test bus error done");
    endtask
    task automatic t_scan;
        m.wr(A_TC, 16'h0002, 1'b0);
        m.wr(A_CT, 16'h0010, 1'b0);
        wait_ev;
        rd_chk(A_RO, rem_w);
        wait_ev;
        rd_chk(A_RO, rem_w);
        check(16'(n_att), 16'h0000);
        m.wr(A_TC, 16'h0003, 1'b0);
        wait_ev;
        m.rd(A_RO, d, v);
        exp_w = d[2] ? loc_w : rem_w;
        wait_ev;
        rd_chk(A_RO, exp_w);
        repeat (20) @(negedge mclk);
        rd_chk(A_ST, 16'h0011);
        m.wr(A_CT, 16'h0000, 1'b0);
        m.rd(A_RO, d, v);
        repeat (20) @(negedge mclk);
        rd_chk(A_RO, d);
        rd_chk(A_ST, 16'h0000);
        $display("test scan done");
    endtask
    task automatic t_rate;
        m.wr(A_TC, 16'h0007, 1'b0);
        m.wr(A_CT, 16'h0010, 1'b0);
        repeat (30) @(negedge mclk);
        check(16'(gap), 16'h0008);
        m.wr(A_CT, 16'h0014, 1'b0);
        repeat (80) @(negedge mclk);
        check(16'(gap), 16'h0020);
        check({15'h0, low_power_active}, 16'h0001);
        m.wr(A_CT, 16'h0016, 1'b0);
        repeat (2) @(negedge mclk);
        d = 16'(n_att);
        repeat (40) @(negedge mclk);
        check(16'(n_att), d);
        $display("test rate done");
    endtask
    task automatic t_devrst;
        @(negedge mclk) nack_event = 1'b1;
        @(negedge mclk) nack_event = 1'b0;
        m.wr(A_CT, 16'h0021, 1'b0);
        check({15'h0, device_reset_busy}, 16'h0001);
        check({15'h0, function_two_enable}, 16'h0001);
        repeat (8) @(negedge mclk);
        rd_chk(A_CT, 16'h0000);
        rd_chk(A_TC, 16'h0000);
        rd_chk(A_ST, 16'h0000);
        check({15'h0, function_two_enable}, 16'h0000);
        $display("test device reset done");
    endtask
    // verdict and end of run
    task automatic test_done;
        $display("checks=%0d mismatches=%0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // watchdog
    initial begin
        #100us;
        failures++;
        test_done;
    end
    // main sequence
    initial begin
        {rst_n, ce, nack_event, remote_fault} = 4'h5;
        {local_temp, remote_temp} = {10'h155, 10'h2aa};
        loc_w = {10'h155, 6'h00};
        rem_w = {10'h2aa, 6'h06};
        repeat (20) @(negedge mclk);
        rst_n = 1'b1;
        t_regs;
        t_berr;
        t_scan;
        t_rate;
        t_devrst;
        test_done;
    end
endmodule
`default_nettype wire

// File: temp_monitor_control_status.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module temp_monitor_control_status #(
    parameter int SLOT_CYCLES = temp_monitor_pkg::SLOT_CYCLES_DEF  // cycles per conversion slot
) (
    // clock, reset, enable
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // register access from the bus framing logic
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic        reg_bcast,
    input  wire logic [5:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    output logic             reg_rvalid,
    // acknowledge error seen or sent by the framing logic
    input  wire logic        nack_event,
    // converter results, same clock domain
    input  wire logic [9:0]  local_temp,
    input  wire logic [9:0]  remote_temp,
    input  wire logic        remote_fault,
    // device-level status towards the rest of the chip
    output logic             attention_req,
    output logic             shutdown_active,
    output logic             low_power_active,
    output logic             function_two_enable,
    output logic             device_reset_busy,
    output logic      [3:0]  function_type_code
);
    ////////////////////////////////////////////////////////////////////////////
    // state
    logic [15:0]                  ctrl_reg, ctrl_next;          // device control
    logic [15:0]                  tctrl_reg, tctrl_next;        // temperature control
    logic [15:0]                  readout_reg, readout_next;    // last stored result
    logic                         event_reg, event_next;        // function one event
    logic                         err_reg, err_next;            // function one overrun
    logic                         ber_reg, ber_next;            // bus error flag
    logic                         cur_reg, cur_next;            // last scanned sensor
    logic [27:0]                  slot_cnt_reg, slot_cnt_next;  // conversion slot timer
    logic [2:0]                   rst_cnt_reg, rst_cnt_next;    // reset operation timer
    temp_monitor_pkg::dev_state_t dev_state_reg, dev_state_next;
    logic [15:0]                  rdata_next;
    logic                         rvalid_next;
    logic                         attn_next;
    logic [3:0]                   ftype_next;
    // combinational helpers
    logic                         scan_run;                     // scan allowed this cycle
    logic                         sample;                       // store a new result now
    logic                         nxt;                          // sensor chosen for the slot
    logic [27:0]                  slot_limit;                   // last count of a slot
    logic                         readout_read;                 // readout register read
    logic                         status_read;                  // device status read
    logic [1:0]                   sens_en;                      // per-sensor enables
    logic [9:0]                   sel_temp;                     // value of chosen sensor
    logic                         sel_fault;                    // fault of chosen sensor

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic for all registers
    always_comb begin
        ctrl_next      = ctrl_reg;
        tctrl_next     = tctrl_reg;
        readout_next   = readout_reg;
        event_next     = event_reg;
        err_next       = err_reg;
        ber_next       = ber_reg;
        cur_next       = cur_reg;
        slot_cnt_next  = slot_cnt_reg;
        rst_cnt_next   = rst_cnt_reg;
        dev_state_next = dev_state_reg;
        rdata_next     = reg_rdata;
        rvalid_next    = 1'b0;
        attn_next      = 1'b0;
        ftype_next     = temp_monitor_pkg::FUNC_TYPE_TEMP;
        sample         = 1'b0;
        sens_en[0]     = tctrl_reg[temp_monitor_pkg::TCTL_LOCAL_EN_BIT];
        sens_en[1]     = tctrl_reg[temp_monitor_pkg::TCTL_REMOTE_EN_BIT];
        readout_read   = reg_rd && (reg_addr == temp_monitor_pkg::OFS_TEMP_READOUT);
        status_read    = reg_rd && (reg_addr == temp_monitor_pkg::OFS_DEVICE_STATUS);
        // scan halts in shutdown, when disabled, or with no sensor on
        scan_run = !ctrl_reg[temp_monitor_pkg::CTL_SHUTDOWN_BIT]
                   && ctrl_reg[temp_monitor_pkg::CTL_F1_ENABLE_BIT]
                   && (|sens_en)
                   && (dev_state_reg == temp_monitor_pkg::DEV_ACTIVE);
        // low power stretches every slot by four
        if (ctrl_reg[temp_monitor_pkg::CTL_LOW_POWER_BIT]) begin
            slot_limit = 28'(SLOT_CYCLES * temp_monitor_pkg::LOW_POWER_FACTOR - 1);
        end else begin
            slot_limit = 28'(SLOT_CYCLES - 1);
        end
        // next enabled sensor above the last one, wrapping round
        if (sens_en[~cur_reg]) begin
            nxt = ~cur_reg;
        end else begin
            nxt = cur_reg;
        end
        if (nxt) begin
            sel_temp  = remote_temp;
            sel_fault = remote_fault;
        end else begin
            sel_temp  = local_temp;
            sel_fault = 1'b0;
        end
        // slot timer
        if (scan_run) begin
            if (slot_cnt_reg >= slot_limit) begin
                slot_cnt_next = 28'h0000000;
                sample        = 1'b1;
            end else begin
                slot_cnt_next = slot_cnt_reg + 28'h0000001;
            end
        end else begin
            slot_cnt_next = 28'h0000000;
        end
        // store result: value, sensor number, fault bit
        if (sample) begin
            readout_next = {sel_temp, 3'h0, nxt, sel_fault, 1'h0};
            cur_next     = nxt;
        end
        // event and overrun flags; a new result wins over the read clear for the event flag, the read clear wins for overrun
        event_next = sample || (event_reg && !readout_read);
        err_next   = (sample && event_reg && !readout_read)
                     || (err_reg && !readout_read);
        attn_next  = sample && tctrl_reg[temp_monitor_pkg::TCTL_ATTN_EN_BIT];
        // bus error: a new nack wins over the status read clear
        ber_next = nack_event || (ber_reg && !status_read);
        // register reads
        if (reg_rd) begin
            rvalid_next = 1'b1;
            if (reg_addr == temp_monitor_pkg::OFS_DEVICE_STATUS) begin
                rdata_next = 16'h0000;
                rdata_next[temp_monitor_pkg::STS_F1_EVENT_BIT]  = event_reg;
                rdata_next[temp_monitor_pkg::STS_F1_ERROR_BIT]  = err_reg;
                rdata_next[temp_monitor_pkg::STS_BUS_ERROR_BIT] = ber_reg;
            end else if (reg_addr == temp_monitor_pkg::OFS_DEVICE_CONTROL) begin
                rdata_next = ctrl_reg & temp_monitor_pkg::CTL_WRITE_MASK;
            end else if (reg_addr == temp_monitor_pkg::OFS_TEMP_CAPS) begin
                rdata_next = temp_monitor_pkg::TEMP_CAPS_VAL;
            end else if (reg_addr == temp_monitor_pkg::OFS_TEMP_READOUT) begin
                rdata_next = readout_reg;
            end else if (reg_addr == temp_monitor_pkg::OFS_TEMP_CONTROL) begin
                rdata_next = tctrl_reg & temp_monitor_pkg::TCTL_WRITE_MASK;
            end else begin
                rdata_next = 16'h0000;                                          // unmapped
            end
        end
        // register writes, ignored while a reset operation runs
        if (reg_wr && (dev_state_reg == temp_monitor_pkg::DEV_ACTIVE)) begin
            if (reg_addr == temp_monitor_pkg::OFS_DEVICE_CONTROL) begin
                if (reg_bcast) begin
                    ctrl_next = (ctrl_reg & ~temp_monitor_pkg::CTL_BCAST_MASK)
                                | (reg_wdata & temp_monitor_pkg::CTL_BCAST_MASK);
                end else begin
                    ctrl_next = reg_wdata & temp_monitor_pkg::CTL_WRITE_MASK;
                end
            end else if (!reg_bcast && (reg_addr == temp_monitor_pkg::OFS_TEMP_CONTROL)) begin
                tctrl_next = reg_wdata & temp_monitor_pkg::TCTL_WRITE_MASK;
            end
        end
        // device reset sequencer
        case (dev_state_reg)
            temp_monitor_pkg::DEV_ACTIVE: begin
                if (ctrl_next[temp_monitor_pkg::CTL_RESET_BIT]) begin
                    dev_state_next = temp_monitor_pkg::DEV_RESETTING;
                    rst_cnt_next   = temp_monitor_pkg::DEVRST_CYCLES - 3'h1;
                end
            end
            temp_monitor_pkg::DEV_RESETTING: begin
                if (rst_cnt_reg == 3'h0) begin
                    // finish: control, readout and flags back to reset value (a nack in this cycle still sets the bus error flag), bit 0 clears itself
                    dev_state_next = temp_monitor_pkg::DEV_ACTIVE;
                    ctrl_next      = temp_monitor_pkg::CTL_RESET_VAL;
                    tctrl_next     = temp_monitor_pkg::TCTL_RESET_VAL;
                    readout_next   = temp_monitor_pkg::READOUT_RESET_VAL;
                    event_next     = 1'b0;
                    err_next       = 1'b0;
                    ber_next       = nack_event;
                    cur_next       = 1'b1;
                end else begin
                    rst_cnt_next = rst_cnt_reg - 3'h1;
                end
            end
            default: begin
                dev_state_next = temp_monitor_pkg::DEV_ACTIVE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers, frozen while ce is low
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctrl_reg           <= temp_monitor_pkg::CTL_RESET_VAL;
            tctrl_reg          <= temp_monitor_pkg::TCTL_RESET_VAL;
            readout_reg        <= temp_monitor_pkg::READOUT_RESET_VAL;
            event_reg          <= 1'b0;
            err_reg            <= 1'b0;
            ber_reg            <= 1'b0;
            cur_reg            <= 1'b1;   // first slot lands on sensor 0 if it is enabled
            slot_cnt_reg       <= 28'h0000000;
            rst_cnt_reg        <= 3'h0;
            dev_state_reg      <= temp_monitor_pkg::DEV_ACTIVE;
            reg_rdata          <= 16'h0000;
            reg_rvalid         <= 1'b0;
            attention_req      <= 1'b0;
            function_type_code <= temp_monitor_pkg::FUNC_TYPE_TEMP;
        end else if (ce) begin
            ctrl_reg           <= ctrl_next;
            tctrl_reg          <= tctrl_next;
            readout_reg        <= readout_next;
            event_reg          <= event_next;
            err_reg            <= err_next;
            ber_reg            <= ber_next;
            cur_reg            <= cur_next;
            slot_cnt_reg       <= slot_cnt_next;
            rst_cnt_reg        <= rst_cnt_next;
            dev_state_reg      <= dev_state_next;
            reg_rdata          <= rdata_next;
            reg_rvalid         <= rvalid_next;
            attention_req      <= attn_next;
            function_type_code <= ftype_next;
        end
    end

    // mode outputs straight from the control flip-flops
    assign shutdown_active     = ctrl_reg[temp_monitor_pkg::CTL_SHUTDOWN_BIT];
    assign low_power_active    = ctrl_reg[temp_monitor_pkg::CTL_LOW_POWER_BIT];
    assign function_two_enable = ctrl_reg[temp_monitor_pkg::CTL_F2_ENABLE_BIT];
    assign device_reset_busy   = ctrl_reg[temp_monitor_pkg::CTL_RESET_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n || !ce);

    // a full control write that starts a reset operation
    sequence s_reset_start;
        reg_wr && !reg_bcast && (reg_addr == temp_monitor_pkg::OFS_DEVICE_CONTROL)
        && reg_wdata[0] && (dev_state_reg == temp_monitor_pkg::DEV_ACTIVE);
    endsequence
    sequence s_reset_done;
        (dev_state_reg == temp_monitor_pkg::DEV_RESETTING) [*4] ##1 (ctrl_reg == 16'h0000);
    endsequence

    property p_ber_set;
        nack_event |=> ber_reg;
    endproperty
    a_ber_set: assert property (p_ber_set) else $error("bus error flag not set by nack");

    property p_ber_clear;
        status_read && !nack_event && (dev_state_reg == temp_monitor_pkg::DEV_ACTIVE) |=> !ber_reg;
    endproperty
    a_ber_clear: assert property (p_ber_clear) else $error("bus error flag survived status read");

    property p_bcast;
        reg_wr && reg_bcast && (reg_addr == temp_monitor_pkg::OFS_DEVICE_CONTROL)
        && (dev_state_reg == temp_monitor_pkg::DEV_ACTIVE) && !reg_wdata[0]
        |=> ctrl_reg[15:2] == $past(ctrl_reg[15:2]);
    endproperty
    a_bcast: assert property (p_bcast) else $error("broadcast write changed upper control bits");

    property p_reset_op;
        s_reset_start |=> s_reset_done;
    endproperty
    a_reset_op: assert property (p_reset_op) else $error("reset operation did not clear control");

    property p_unimpl;
        (ctrl_reg[3] == 1'b0) && (ctrl_reg[15:6] == 10'h000);
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimplemented control bit set");

    property p_stop_hold;
        (!scan_run && (dev_state_reg == temp_monitor_pkg::DEV_ACTIVE)) |=> $stable(readout_reg);
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("readout changed while scan stopped");

    property p_low_rate;
        sample && ctrl_reg[temp_monitor_pkg::CTL_LOW_POWER_BIT]
        |-> slot_cnt_reg == 28'(SLOT_CYCLES * temp_monitor_pkg::LOW_POWER_FACTOR - 1);
    endproperty
    a_low_rate: assert property (p_low_rate) else $error("low power slot length wrong");

    property p_pick;
        sample |-> sens_en[nxt] && ((sens_en == 2'h3) -> (nxt != cur_reg));
    endproperty
    a_pick: assert property (p_pick) else $error("scan picked wrong sensor");

    property p_event;
        sample |=> event_reg && (readout_reg[temp_monitor_pkg::RO_SNUM_BIT] == $past(nxt));
    endproperty
    a_event: assert property (p_event) else $error("event flag or sensor number wrong");

    property p_read_clear;
        readout_read && !sample && (dev_state_reg == temp_monitor_pkg::DEV_ACTIVE) |=> !event_reg && !err_reg;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("readout read left flags set");

    property p_overrun;
        sample && event_reg && !readout_read |=> err_reg;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged");

    property p_attn;
        attention_req |-> $past(sample) && $past(tctrl_reg[temp_monitor_pkg::TCTL_ATTN_EN_BIT]);
    endproperty
    a_attn: assert property (p_attn) else $error("attention request without cause");

    property p_caps;
        reg_rd && (reg_addr == temp_monitor_pkg::OFS_TEMP_CAPS) |=> reg_rvalid && (reg_rdata == 16'h0349);
    endproperty
    a_caps: assert property (p_caps) else $error("capabilities read wrong");
endmodule
`default_nettype wire

// File: temp_monitor_pkg.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
package temp_monitor_pkg;
    // register offsets on the management bus (6-bit register address)
    localparam logic [5:0]  OFS_DEVICE_STATUS   = 6'h04;
    localparam logic [5:0]  OFS_DEVICE_CONTROL  = 6'h05;
    localparam logic [5:0]  OFS_TEMP_CAPS       = 6'h08;
    localparam logic [5:0]  OFS_TEMP_READOUT    = 6'h09;
    localparam logic [5:0]  OFS_TEMP_CONTROL    = 6'h0a;
    // device control field positions
    localparam int          CTL_RESET_BIT       = 0;
    localparam int          CTL_SHUTDOWN_BIT    = 1;
    localparam int          CTL_LOW_POWER_BIT   = 2;
    localparam int          CTL_F1_ENABLE_BIT   = 4;
    localparam int          CTL_F2_ENABLE_BIT   = 5;
    // writable bits of device control, and the part a broadcast may touch
    localparam logic [15:0] CTL_WRITE_MASK      = 16'h0037;
    localparam logic [15:0] CTL_BCAST_MASK      = 16'h0003;
    localparam logic [15:0] CTL_RESET_VAL       = 16'h0000;
    // device status field positions
    localparam int          STS_F1_EVENT_BIT    = 0;
    localparam int          STS_F1_ERROR_BIT    = 4;
    localparam int          STS_BUS_ERROR_BIT   = 7;
    // temperature control field positions
    localparam int          TCTL_LOCAL_EN_BIT   = 0;
    localparam int          TCTL_REMOTE_EN_BIT  = 1;
    localparam int          TCTL_ATTN_EN_BIT    = 2;
    localparam logic [15:0] TCTL_WRITE_MASK     = 16'h0007;
    localparam logic [15:0] TCTL_RESET_VAL      = 16'h0000;
    // fixed capability word and function identity
    localparam logic [15:0] TEMP_CAPS_VAL       = 16'h0349;
    localparam logic [3:0]  FUNC_TYPE_TEMP      = 4'h1;
    // readout layout
    localparam int          RO_EF_BIT           = 1;
    localparam int          RO_SNUM_BIT         = 2;
    localparam int          RO_TEMP_LSB         = 6;
    localparam logic [15:0] READOUT_RESET_VAL   = 16'h0000;
    localparam int          NUM_SENSORS         = 2;
    // timing
    localparam int          CLK_PERIOD_NS       = 10;
    localparam int          SLOT_TIME_MS        = 100;
    localparam int          SLOT_CYCLES_DEF     = SLOT_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int          LOW_POWER_FACTOR    = 4;
    localparam logic [2:0]  DEVRST_CYCLES       = 3'h4;
    // device reset sequencer states
    typedef enum logic [0:0] {
        DEV_ACTIVE    = 1'b0,
        DEV_RESETTING = 1'b1
    } dev_state_t;
endpackage
`default_nettype wire
